// *** verilog/sfr_pkg.sv ***
package sfr_pkg;
  // register addresses
  localparam logic [5:0] ADDR_WINDOW  = 6'h00;
  localparam logic [5:0] ADDR_TIMER   = 6'h01;
  localparam logic [5:0] ADDR_PCL     = 6'h02;
  localparam logic [5:0] ADDR_STATUS  = 6'h03;
  localparam logic [5:0] ADDR_PTR     = 6'h04;
  localparam logic [5:0] ADDR_PORT_A_DATA   = 6'h05;
  localparam logic [5:0] ADDR_PORT_B_DATA   = 6'h06;
  localparam logic [5:0] ADDR_CHIP_CONTROL = 6'h07;
  localparam logic [5:0] ADDR_WAKE    = 6'h0B;
  localparam logic [5:0] ADDR_CPER    = 6'h0C;
  localparam logic [5:0] ADDR_CHIGH   = 6'h0D;
  localparam logic [5:0] ADDR_KEY     = 6'h0E;
  localparam logic [5:0] ADDR_CSEL    = 6'h0F;
  // status bit positions
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  // chip control bit positions
  localparam int CC_CARRIER_GEN_ENABLE  = 0;
  localparam int CC_CARRIER_PIN_ENABLE = 2;
  localparam int CC_HW_KEYSCAN_ENABLE = 3;
  localparam int CC_LVD   = 6;
  localparam int CC_WDT   = 7;
  localparam logic [7:0] CC_MASK     = 8'hCD;
  localparam logic [7:0] PTR_TOP     = 8'hC0;
  localparam logic [7:0] PORT_MASK   = 8'h3F;
  localparam logic [7:0] CSEL_MASK   = 8'h0F;
  localparam logic [7:0] STATUS_RST  = 8'h18;
  localparam logic [8:0] PC_RESET    = 9'h1FF;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] PRESC_RST   = 8'hFF;
  // pc operation codes from the datapath
  typedef enum logic [2:0] {
    PC_STEP = 3'h0,
    PC_JUMP = 3'h1,
    PC_CALL = 3'h2,
    PC_RET  = 3'h3,
    PC_HOLD = 3'h4
  } pc_op_t;
  // one register access from the datapath
  typedef struct packed {
    logic       wr;
    logic [5:0] addr;
    logic [7:0] wdata;
  } sfr_acc_t;
  // flag update from the alu
  typedef struct packed {
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic c;
    logic dc;
    logic z;
  } alu_flags_t;
  // carry and half carry of a + b + cin
  function automatic logic [1:0] add_flags(input logic [7:0] a,
                                            input logic [7:0] b,
                                            input logic       cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {full[8], low[4]};
  endfunction
endpackage

// *** verilog/core_special_register_file.sv ***
`timescale 1ns/1ps
module core_special_register_file
  import sfr_pkg::*;
#(
  parameter int PORT_W = 6
)(
  input  wire logic                CLK,
  input  wire logic                RST_N,
  input  wire sfr_pkg::sfr_acc_t   ACC,
  output      logic [7:0]          RDATA,
  input  wire sfr_pkg::alu_flags_t FLAGS,
  input  wire sfr_pkg::pc_op_t     PC_OP,
  input  wire logic [8:0]          PC_TARGET,
  output      logic [8:0]          PC,
  output      logic [5:0]          GPR_ADDR,
  output      logic                GPR_WR,
  input  wire logic [7:0]          GPR_RDATA,
  input  wire logic                CLEAR_WATCHDOG_INSTR_INSTR,
  input  wire logic                SLEEP_INSTR,
  input  wire logic                WDT_OVERFLOW,
  input  wire logic                TIMER_SRC_SEL,
  input  wire logic                TIMER_EDGE_SEL,
  input  wire logic                PRESCALER_ASSIGN,
  input  wire logic                PRESCALE_TICK,
  output      logic                PRESCALER_CLEAR,
  input  wire logic [PORT_W-1:0]   PORT_A_PINS,
  input  wire logic [PORT_W-1:0]   PORT_B_PINS,
  output      logic [PORT_W-1:0]   PORT_A_LATCH,
  output      logic [PORT_W-1:0]   PORT_B_LATCH,
  output      logic                WAKE_EVENT,
  output      logic                IR_CARRIER,
  output      logic                IR_PIN,
  input  wire logic                KEYBOARD_TYPE_SELECT,
  output      logic                KEYSCAN_ACTIVE,
  output      logic                WATCHDOG_ENABLE,
  output      logic                LOW_VOLTAGE_DETECT_ENABLE,
  input  wire logic [7:0]          KEY_CODE_IN,
  input  wire logic [3:0]          CUSTOM_CODE_IN
);
  import sfr_pkg::*;

  initial if (PORT_W != 6) $error("PORT_W must be 6");

  logic [7:0]        tmr_r, ptr_r, status_r, cc_r, wake_r;
  logic [7:0]        cper_r, chigh_r, ccnt_r;
  logic [8:0]        pc_r, stk0_r, stk1_r;
  logic [PORT_W-1:0] pa_r, pb_r, pa_s1, pa_s2, pb_s1, pb_s2, pb_old_r;
  logic              car_r, car_old_r;

  // window redirect; pointer zero turns the access into a no-op
  // window redirect
  wire [5:0] eff_addr  = (ACC.addr == ADDR_WINDOW) ? ptr_r[5:0] : ACC.addr;
  wire       via_win   = (ACC.addr == ADDR_WINDOW);
  wire       null_acc  = via_win && (ptr_r[5:0] == ADDR_WINDOW);
  wire       wr_ok     = ACC.wr && !null_acc;
  wire       wr_tmr    = wr_ok && (eff_addr == ADDR_TIMER);
  wire       wr_pcl    = wr_ok && (eff_addr == ADDR_PCL);
  wire       wr_stat   = wr_ok && (eff_addr == ADDR_STATUS);
  wire       wr_ptr    = wr_ok && (eff_addr == ADDR_PTR);
  wire       is_sfr    = (eff_addr <= ADDR_CSEL) && (eff_addr != 6'h08)
                         && (eff_addr != 6'h09) && (eff_addr != 6'h0A);

  assign GPR_ADDR = eff_addr;
  assign GPR_WR   = wr_ok && !is_sfr;

  // pin synchronisers; only the second stage is read
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      pa_s1 <= '0; pa_s2 <= '0; pb_s1 <= '0; pb_s2 <= '0;
    end
    else
    begin
      pa_s1 <= PORT_A_PINS; pa_s2 <= pa_s1;
      pb_s1 <= PORT_B_PINS; pb_s2 <= pb_s1;
    end

  // read mux
  always_comb
  begin
    RDATA = ZERO8;
    if (!null_acc)
      unique case (eff_addr)
        ADDR_TIMER:   RDATA = tmr_r;
        ADDR_PCL:     RDATA = pc_r[7:0];
        ADDR_STATUS:  RDATA = status_r;
        ADDR_PTR:     RDATA = ptr_r | PTR_TOP;
        ADDR_PORT_A_DATA:   RDATA = {2'b00, pa_s2};
        ADDR_PORT_B_DATA:   RDATA = {2'b00, pb_s2};
        ADDR_CHIP_CONTROL: RDATA = cc_r & CC_MASK;
        ADDR_KEY:     RDATA = KEY_CODE_IN;
        ADDR_CSEL:    RDATA = {4'h0, CUSTOM_CODE_IN} & CSEL_MASK;
        ADDR_WAKE, ADDR_CPER, ADDR_CHIGH: RDATA = ZERO8; // write-only
        default:      RDATA = is_sfr ? ZERO8 : GPR_RDATA;
      endcase
  end

  // timer clock select and edge detection of carrier
  // source and edge
  wire car_edge  = TIMER_EDGE_SEL ? (car_old_r && !car_r)
                                  : (!car_old_r && car_r);
  wire raw_tick  = TIMER_SRC_SEL ? car_edge : 1'b1;
  // without prescaler the raw tick counts; with it, the prescaler output
  wire tmr_tick  = PRESCALER_ASSIGN ? raw_tick : (raw_tick && PRESCALE_TICK);
  assign PRESCALER_CLEAR = wr_tmr && !PRESCALER_ASSIGN;

  // timer count; a write wins over an increment
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
      tmr_r <= ZERO8;
    else if (wr_tmr)
      tmr_r <= ACC.wdata;
    else if (tmr_tick)
      tmr_r <= tmr_r + 8'h01;

  // program counter and two-entry stack
  wire [8:0] pc_inc = pc_r + 9'h001;
  logic [8:0] pc_nxt;
  always_comb
  begin
    pc_nxt = pc_r;
    unique case (PC_OP)
      PC_STEP: pc_nxt = pc_inc;
      PC_JUMP: pc_nxt = PC_TARGET;
      PC_CALL: pc_nxt = PC_TARGET;
      PC_RET:  pc_nxt = stk0_r;
      PC_HOLD: pc_nxt = pc_r;
      default: pc_nxt = pc_r;
    endcase
    if (wr_pcl)
      pc_nxt = {1'b0, ACC.wdata};
  end

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      pc_r <= PC_RESET; stk0_r <= '0; stk1_r <= '0;
    end
    else
    begin
      pc_r <= pc_nxt;
      if (PC_OP == PC_CALL)
      begin
        stk0_r <= pc_inc; stk1_r <= stk0_r;
      end
      else if (PC_OP == PC_RET)
        stk0_r <= stk1_r;
    end
  assign PC = pc_r;

  // status: alu flags override writes; reset flags follow instructions
  logic [7:0] st_nxt;
  always_comb
  begin
    st_nxt = status_r;
    if (wr_stat)
      st_nxt[7:5] = ACC.wdata[7:5];
    if (wr_stat && !FLAGS.upd_c)  st_nxt[ST_C]  = ACC.wdata[ST_C];
    if (wr_stat && !FLAGS.upd_dc) st_nxt[ST_DC] = ACC.wdata[ST_DC];
    if (wr_stat && !FLAGS.upd_z)  st_nxt[ST_Z]  = ACC.wdata[ST_Z];
    if (FLAGS.upd_c)  st_nxt[ST_C]  = FLAGS.c;
    if (FLAGS.upd_dc) st_nxt[ST_DC] = FLAGS.dc;
    if (FLAGS.upd_z)  st_nxt[ST_Z]  = FLAGS.z;
    if (CLEAR_WATCHDOG_INSTR_INSTR) st_nxt[ST_PD] = 1'b1;
    else if (SLEEP_INSTR) st_nxt[ST_PD] = 1'b0;
    // expiry flag; overflow is the event, so it wins
    if (WDT_OVERFLOW) st_nxt[ST_TO] = 1'b0;
    else if (CLEAR_WATCHDOG_INSTR_INSTR || SLEEP_INSTR) st_nxt[ST_TO] = 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) status_r <= STATUS_RST;
    else        status_r <= st_nxt;

  // plain control registers
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      ptr_r <= PTR_TOP; pa_r <= '0; pb_r <= '0; cc_r <= ZERO8;
      wake_r <= ZERO8; cper_r <= ZERO8; chigh_r <= ZERO8;
    end
    else if (wr_ok)
    begin
      if (wr_ptr) ptr_r <= ACC.wdata | PTR_TOP;
      if (eff_addr == ADDR_PORT_A_DATA) pa_r <= ACC.wdata[PORT_W-1:0];
      if (eff_addr == ADDR_PORT_B_DATA) pb_r <= ACC.wdata[PORT_W-1:0];
      if (eff_addr == ADDR_CHIP_CONTROL) cc_r <= ACC.wdata & CC_MASK;
      if (eff_addr == ADDR_WAKE) wake_r <= ACC.wdata & PORT_MASK;
      if (eff_addr == ADDR_CPER) cper_r <= ACC.wdata;
      if (eff_addr == ADDR_CHIGH) chigh_r <= ACC.wdata;
    end
  assign PORT_A_LATCH = pa_r;
  assign PORT_B_LATCH = pb_r;
  assign WATCHDOG_ENABLE = cc_r[CC_WDT];
  assign LOW_VOLTAGE_DETECT_ENABLE = cc_r[CC_LVD];
  assign KEYSCAN_ACTIVE = cc_r[CC_HW_KEYSCAN_ENABLE] && !KEYBOARD_TYPE_SELECT;

  // wake on enabled falling port B edges
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N) pb_old_r <= '0;
    else        pb_old_r <= pb_s2;
  assign WAKE_EVENT = |(pb_old_r & ~pb_s2 & wake_r[PORT_W-1:0]);

  // carrier generator; high count below period is software's duty
  // divide by period
  wire [7:0] cnt_nxt = (ccnt_r + 8'h01 >= cper_r) ? ZERO8 : ccnt_r + 8'h01;
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      ccnt_r <= ZERO8; car_r <= 1'b0; car_old_r <= 1'b0;
    end
    else
    begin
      car_old_r <= car_r;
      if (!cc_r[CC_CARRIER_GEN_ENABLE])
      begin
        ccnt_r <= ZERO8; car_r <= 1'b0;
      end
      else
      begin
        ccnt_r <= cnt_nxt;
        car_r  <= (cnt_nxt < chigh_r);
      end
    end
  assign IR_CARRIER = car_r;
  assign IR_PIN = car_r && cc_r[CC_CARRIER_PIN_ENABLE];

  // checks
  chk_ptr_top: assert property (@(posedge CLK) disable iff (!RST_N)
    (ACC.addr == ADDR_PTR) |-> RDATA[7:6] == 2'b11)
    else $error("pointer top bits not ones");
  chk_null_win: assert property (@(posedge CLK) disable iff (!RST_N)
    null_acc |-> (RDATA == ZERO8 && !GPR_WR))
    else $error("null window access leaked");
  chk_pcl_clr: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_pcl |=> PC == {1'b0, $past(ACC.wdata)})
    else $error("pc low write wrong");
  chk_call_ret: assert property (@(posedge CLK) disable iff (!RST_N)
    (PC_OP == PC_CALL && !wr_pcl) ##1 (PC_OP == PC_RET && !wr_pcl)
      |=> PC == $past(PC, 2) + 9'h001)
    else $error("return address wrong");
  chk_jump_pc: assert property (@(posedge CLK) disable iff (!RST_N)
    (PC_OP == PC_JUMP && !wr_pcl) |=> PC == $past(PC_TARGET))
    else $error("jump target wrong");
  chk_to_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    WDT_OVERFLOW |=> !status_r[ST_TO])
    else $error("expiry flag not cleared");
  chk_pd_flag: assert property (@(posedge CLK) disable iff (!RST_N)
    (SLEEP_INSTR && !CLEAR_WATCHDOG_INSTR_INSTR) |=> !status_r[ST_PD])
    else $error("powerdown flag not cleared");
  chk_presc_clr: assert property (@(posedge CLK) disable iff (!RST_N)
    PRESCALER_CLEAR |-> (!PRESCALER_ASSIGN && ACC.wr))
    else $error("spurious prescaler clear");
  chk_key_mode: assert property (@(posedge CLK) disable iff (!RST_N)
    KEYBOARD_TYPE_SELECT |-> !KEYSCAN_ACTIVE)
    else $error("key scan outside T-type");
  chk_carrier_off: assert property (@(posedge CLK) disable iff (!RST_N)
    !cc_r[CC_CARRIER_GEN_ENABLE] |=> !IR_CARRIER)
    else $error("carrier on while disabled");
  chk_tmr_write: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_tmr |=> tmr_r == $past(ACC.wdata))
    else $error("timer write lost");
endmodule // core_special_register_file

// *** tb/gpr_model.sv ***
`timescale 1ns/1ps
// general registers behind the block, seen by the resolved address
module gpr_model (
  input  wire logic       clk,
  input  wire logic [5:0] addr,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output      logic [7:0] rdata
);
  logic [7:0] mem [64];

  // same-cycle read, so window reads need no wait state
  assign rdata = mem[addr];

  // write lands on the rising edge, as a register file would
  always_ff @(posedge clk)
  begin
    if (wr)
      mem[addr] <= wdata;
  end
endmodule // gpr_model

// *** tb/core_special_register_file_test.sv ***
`timescale 1ns/1ps
module core_special_register_file_test;
  import sfr_pkg::*;
  typedef struct packed {
    logic [2:0] k;
    logic [8:0] v;
  } note_t;
  logic        clk     = 1'h0;
  logic        rst_n   = 1'h0;
  sfr_acc_t    acc     = '0;
  alu_flags_t  flags   = '0;
  pc_op_t      pc_op   = PC_HOLD;
  logic [8:0]  pc_tgt  = 9'h000;
  logic [2:0]  pul     = 3'h0;
  logic        kts     = 1'h0;
  logic        prescaler_assign     = 1'h1;
  logic        tsrc    = 1'h0;
  logic        tedge   = 1'h0;
  logic        ptick   = 1'h0;
  logic [5:0]  pa_latch;
  logic        wdt_en;
  logic        lvd_en;
  logic [5:0]  pa_pins = 6'h00;
  logic [5:0]  pb_pins = 6'h3F;
  logic [7:0]  key_in  = 8'hFF;
  logic [3:0]  cs_in   = 4'h0;
  logic        look_r  = 1'h0;
  logic [31:0] seed_r  = 32'hD7849ADA;
  logic [8:0]  meas_r;
  logic [8:0]  ob;
  logic [7:0]  rdata;
  logic [8:0]  pc;
  logic [5:0]  gaddr;
  logic [7:0]  grdata;
  logic [5:0]  pb_latch;
  logic        gwr;
  logic        pclr;
  logic        wake;
  logic        ir_car;
  logic        ir_pin;
  logic        ks_act;
  note_t       n;
  note_t       exp_q[$];
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  string       nm[8] = '{"none", "rdata", "pc", "latch", "keyscan",
                         "count", "presc_clr", "ctrl_out"};

  core_special_register_file DUT (
    .CLK(clk), .RST_N(rst_n), .ACC(acc), .RDATA(rdata), .FLAGS(flags),
    .PC_OP(pc_op), .PC_TARGET(pc_tgt), .PC(pc), .GPR_ADDR(gaddr),
    .GPR_WR(gwr), .GPR_RDATA(grdata), .CLEAR_WATCHDOG_INSTR_INSTR(pul[2]),
    .SLEEP_INSTR(pul[1]), .WDT_OVERFLOW(pul[0]), .TIMER_SRC_SEL(tsrc),
    .TIMER_EDGE_SEL(tedge), .PRESCALER_ASSIGN(prescaler_assign), .PRESCALE_TICK(ptick),
    .PRESCALER_CLEAR(pclr), .PORT_A_PINS(pa_pins), .PORT_B_PINS(pb_pins),
    .PORT_A_LATCH(pa_latch), .PORT_B_LATCH(pb_latch), .WAKE_EVENT(wake),
    .IR_CARRIER(ir_car), .IR_PIN(ir_pin), .KEYBOARD_TYPE_SELECT(kts),
    .KEYSCAN_ACTIVE(ks_act), .WATCHDOG_ENABLE(wdt_en),
    .LOW_VOLTAGE_DETECT_ENABLE(lvd_en), .KEY_CODE_IN(key_in),
    .CUSTOM_CODE_IN(cs_in));

  gpr_model far_regs (.clk(clk), .addr(gaddr), .wr(gwr),
                      .wdata(acc.wdata), .rdata(grdata));

  // clock of 100 ns
  always #50 clk = ~clk;

  // hang guard: the sequence needs well under this many cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      error_cnt++;
      close_out();
    end
  end

  // outputs are looked at mid-cycle, once every update has landed
  always @(negedge clk)
  begin
    if (look_r)
    begin
      n = exp_q.pop_front();
      case (n.k)
        3'h1: ob = {1'h0, rdata};
        3'h2: ob = pc;
        3'h3: ob = {3'h0, pb_latch};
        3'h4: ob = {8'h00, ks_act};
        3'h5: ob = meas_r;
        3'h6: ob = {8'h00, pclr};
        3'h7: ob = {1'h0, pa_latch, wdt_en, lvd_en};
        default: ob = 9'h1FF;
      endcase
      checks_done++;
      if (ob !== n.v)
      begin
        $display("CHECK FAILED %s expected %h seen %h", nm[n.k], n.v, ob);
        error_cnt++;
      end
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // one datapath cycle; a note is queued when a result is due
  task automatic step(input sfr_acc_t a, input pc_op_t op = PC_HOLD,
                      input logic [8:0] tg = 9'h000,
                      input logic [2:0] k = 3'h0,
                      input logic [8:0] e = 9'h000,
                      input alu_flags_t f = '0,
                      input logic [2:0] p = 3'h0);
    @(posedge clk);
    acc    <= a;
    pc_op  <= op;
    pc_tgt <= tg;
    flags  <= f;
    pul    <= p;
    look_r <= (k != 3'h0);
    if (k != 3'h0)
      exp_q.push_back('{k, e});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    step('{1'h1, a, d});
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    step('{1'h0, a, 8'h00}, PC_HOLD, 9'h000, 3'h1, {1'h0, e});
  endtask

  task automatic chk(input logic [2:0] k, input logic [8:0] e);
    step('0, PC_HOLD, 9'h000, k, e);
  endtask

  task automatic idle(input int c);
    repeat (c) step('0);
  endtask

  // counts high cycles of a chosen output over a window
  task automatic meas(input int s, input int c, input logic [8:0] e);
    int   t;
    logic lv;
    t = 0;
    step('0);
    repeat (c)
    begin
      @(negedge clk);
      lv = (s == 0) ? ir_pin : (s == 1) ? wake : ir_car;
      if (lv === 1'h1)
        t++;
    end
    meas_r = t[8:0];
    chk(3'h5, e);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    logic [31:0] r;
    logic [5:0]  a;
    logic [7:0]  d;
    logic [7:0]  y;
    logic [8:0]  s;
    logic [4:0]  h;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    rd(ADDR_STATUS, 8'h18);
    rd(ADDR_PTR, 8'hC0);
    chk(3'h2, 9'h1FF);
    $display("test reset done");
    repeat (4)
    begin
      seed_r = xs(seed_r);
      r = seed_r;
      a = 6'h10 | r[5:0];
      d = r[15:8];
      wr(a, d);
      wr(ADDR_PTR, {r[23:22], a});
      rd(ADDR_PTR, {2'h3, a});
      rd(ADDR_WINDOW, d);
      wr(ADDR_WINDOW, ~d);
      rd(a, ~d);
    end
    wr(ADDR_PTR, 8'h40);
    wr(ADDR_WINDOW, 8'h5A);
    rd(ADDR_WINDOW, 8'h00);
    $display("test window done");
    step('0, PC_JUMP, 9'h1A5);
    chk(3'h2, 9'h1A5);
    rd(ADDR_PCL, 8'hA5);
    step('0, PC_CALL, 9'h050);
    chk(3'h2, 9'h050);
    step('0, PC_CALL, 9'h0A0);
    chk(3'h2, 9'h0A0);
    step('0, PC_RET);
    chk(3'h2, 9'h051);
    step('0, PC_RET);
    chk(3'h2, 9'h1A6);
    wr(ADDR_PCL, 8'h33);
    chk(3'h2, 9'h033);
    step('0, PC_CALL, 9'h0C0);
    step('0, PC_RET);
    chk(3'h2, 9'h034);
    $display("test pc done");
    step(.a('{1'h1, ADDR_STATUS, 8'h00}), .f('{1'h1, 1'h1, 1'h1, 1'h0,
         1'h0, 1'h1}));
    rd(ADDR_STATUS, 8'h1C);
    wr(ADDR_STATUS, 8'hE7);
    rd(ADDR_STATUS, 8'hFF);
    step(.a('0), .p(3'h2));
    rd(ADDR_STATUS, 8'hF7);
    step(.a('0), .p(3'h1));
    rd(ADDR_STATUS, 8'hE7);
    step(.a('0), .p(3'h4));
    rd(ADDR_STATUS, 8'hFF);
    // random adds and subtracts, subtract as add of the complement
    repeat (6)
    begin
      seed_r = xs(seed_r);
      r = seed_r;
      y = r[16] ? ~r[15:8] : r[15:8];
      s = {1'h0, r[7:0]} + {1'h0, y} + {8'h00, r[16]};
      h = {1'h0, r[3:0]} + {1'h0, y[3:0]} + {4'h0, r[16]};
      step(.a('0), .f('{1'h1, 1'h1, 1'h1, s[8], h[4], s[7:0] == 8'h00}));
      rd(ADDR_STATUS, {5'h1F, s[7:0] == 8'h00, h[4], s[8]});
    end
    $display("test status done");
    pa_pins <= r[5:0];
    idle(3);
    rd(ADDR_PORT_A_DATA, {2'h0, r[5:0]});
    wr(ADDR_PORT_B_DATA, 8'hFF);
    chk(3'h3, 9'h03F);
    wr(ADDR_PORT_A_DATA, 8'hEA);
    chk(3'h7, 9'h0A8);
    wr(ADDR_WAKE, 8'h01);
    rd(ADDR_WAKE, 8'h00);
    pb_pins <= 6'h3E;
    meas(1, 8, 9'h001);
    pb_pins <= 6'h3F;
    wr(ADDR_WAKE, 8'h3E);
    idle(4);
    pb_pins <= 6'h3E;
    meas(1, 8, 9'h000);
    rd(ADDR_PORT_B_DATA, 8'h3E);
    $display("test ports done");
    wr(ADDR_CPER, 8'h05);
    // high count kept below the period
    wr(ADDR_CHIGH, 8'h02);
    wr(ADDR_CHIP_CONTROL, 8'hFF);
    rd(ADDR_CHIP_CONTROL, 8'hCD);
    chk(3'h4, 9'h001);
    chk(3'h7, 9'h0AB);
    idle(1);
    kts <= 1'h1;
    chk(3'h4, 9'h000);
    meas(0, 40, 9'h010);
    wr(ADDR_CHIP_CONTROL, 8'h01);
    meas(0, 40, 9'h000);
    meas(2, 40, 9'h010);
    wr(ADDR_CHIP_CONTROL, 8'h04);
    idle(2);
    meas(2, 40, 9'h000);
    $display("test carrier done");
    key_in <= 8'h41;
    cs_in <= 4'hB;
    rd(ADDR_KEY, 8'h41);
    rd(ADDR_CSEL, 8'h0B);
    idle(1);
    key_in <= 8'hFF;
    rd(ADDR_KEY, 8'hFF);
    step('{1'h1, ADDR_TIMER, 8'h10}, PC_HOLD, 9'h000, 3'h6, 9'h000);
    rd(ADDR_TIMER, 8'h10);
    rd(ADDR_TIMER, 8'h11);
    prescaler_assign <= 1'h0;
    step('{1'h1, ADDR_TIMER, 8'h20}, PC_HOLD, 9'h000, 3'h6, 9'h001);
    rd(ADDR_TIMER, 8'h20);
    rd(ADDR_TIMER, 8'h20);
    ptick <= 1'h1;
    rd(ADDR_TIMER, 8'h21);
    rd(ADDR_TIMER, 8'h22);
    prescaler_assign <= 1'h1;
    tsrc <= 1'h1;
    wr(ADDR_TIMER, 8'h30);
    idle(3);
    rd(ADDR_TIMER, 8'h30);
    // any 25 cycles of a period-5 carrier hold exactly 5 edges
    wr(ADDR_CHIP_CONTROL, 8'h01);
    idle(2);
    wr(ADDR_TIMER, 8'h00);
    idle(25);
    rd(ADDR_TIMER, 8'h05);
    tedge <= 1'h1;
    wr(ADDR_TIMER, 8'h00);
    idle(25);
    rd(ADDR_TIMER, 8'h05);
    $display("test keys and timer done");
    idle(2);
    close_out();
  end
endmodule // core_special_register_file_test
